// ===== hdl/pcc_pkg.sv
// pcc_pkg: constants and types of the clock and power-mode controller.
// assumes: included before hdl/pcc_clock_power_ctrl.sv, used as pcc_pkg::name.
package pcc_pkg;

  // ****************************************
  // multiplication factor field
  // ****************************************
  localparam logic [1:0] FACTOR_X1     = 2'h0;
  localparam logic [1:0] FACTOR_X2     = 2'h1;
  localparam logic [1:0] FACTOR_X4     = 2'h2;
  localparam logic [1:0] FACTOR_BAD    = 2'h3;
  localparam logic [1:0] FACTOR_RESET  = FACTOR_X1;

  // ****************************************
  // divide select field
  // ****************************************
  localparam logic [2:0] DIV_1_1       = 3'h0;
  localparam logic [2:0] DIV_1_32      = 3'h5;
  localparam logic [2:0] DIV_RESET     = DIV_1_1;

  // ****************************************
  // standby wait select, mode bits after reset
  // ****************************************
  localparam logic [3:0] WAIT_SEL_RESET = 4'hf;
  localparam logic [3:0] WAIT_SEL_BAD   = 4'h0;
  localparam logic       SWITCH_MODE_RESET = 1'b0;

  // ****************************************
  // oscillator phase inside the fastest clock
  // ****************************************
  localparam logic [1:0] OSC_PHASE_FIRST = 2'h0;
  localparam logic [1:0] OSC_PHASE_LAST  = 2'h3;
  localparam logic [4:0] DIV_COUNT_RESET = 5'h00;

  // ****************************************
  // operating modes
  // ****************************************
  typedef enum logic [2:0] {
    PCC_RUN,
    PCC_SLEEP,
    PCC_ALL_STOP,
    PCC_SW_STANDBY,
    PCC_WAKE_WAIT,
    PCC_HW_STANDBY
  } pcc_mode_t;

endpackage

// ===== hdl/pcc_clock_power_ctrl.sv
// pcc_clock_power_ctrl: clock multiply/divide enables and power-mode gating.
// assumes: core_clk is the fastest (x4) clock; all slower clocks are enables.
`timescale 1ns/1ps
`default_nettype none

module pcc_clock_power_ctrl #(
  parameter int N_PERIPH        = 8,
  parameter int TIMER_IDX       = 0,
  parameter int SERIAL_IDX      = 1,
  parameter int CONV_IDX        = 2,
  parameter int WAIT_CNT_W      = 24,
  parameter int WAIT_BASE_CYCLES = 64
) (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  pll_factor_hi,
  input  wire logic                  pll_factor_lo,
  input  wire logic                  pll_factor_wr,
  input  wire logic                  factor_switch_mode_bit,
  input  wire logic [2:0]            clock_divide_sel,
  input  wire logic                  clock_divide_wr,
  input  wire logic [3:0]            standby_wait_sel,
  input  wire logic                  standby_wait_wr,
  input  wire logic                  standby_select_bit,
  input  wire logic                  all_stop_select,
  input  wire logic                  sleep_req,
  input  wire logic [N_PERIPH-1:0]   module_stop_reg,
  input  wire logic                  wake_irq_pin,
  input  wire logic                  hw_standby_n_pin,
  output logic                       pll_clk_en,
  output logic                       sys_clk_en,
  output logic                       cpu_clk_en,
  output logic                       watchdog_clk_en,
  output logic [N_PERIPH-1:0]        periph_clk_en,
  output logic [N_PERIPH-1:0]        periph_reset,
  output logic                       cpg_running,
  output logic                       io_hold,
  output logic                       io_hiz,
  output logic [1:0]                 active_factor,
  output logic [2:0]                 active_div,
  output logic [3:0]                 active_wait_sel,
  output pcc_pkg::pcc_mode_t         mode_state
);

  // ****************************************
  // functions
  // ****************************************
  // phase bits that must be all ones for a pll pulse
  function automatic logic [1:0] pll_mask(input logic [1:0] factor);
    logic [1:0] m;
    m = 2'h3;
    if (factor == pcc_pkg::FACTOR_X2) begin
      m = 2'h1;
    end else if (factor == pcc_pkg::FACTOR_X4) begin
      m = 2'h0;
    end
    return m;
  endfunction

  // last count of the divider for a divide code
  function automatic logic [4:0] div_top(input logic [2:0] sel);
    logic [5:0] span;
    span = 6'h01 << sel;
    return 5'(span - 6'h01);
  endfunction

  // system clock periods to wait after a wake
  function automatic logic [WAIT_CNT_W-1:0] wait_cycles(input logic [3:0] sel);
    logic [WAIT_CNT_W-1:0] base;
    base = WAIT_CNT_W'(WAIT_BASE_CYCLES);
    return base << sel;
  endfunction

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  logic       rst_meta_n;
  logic       rst_n;
  logic [1:0] wake_sync;
  logic [1:0] hws_sync;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_sync <= 2'h0;
      hws_sync  <= 2'h3;
    end else begin
      wake_sync <= {wake_sync[0], wake_irq_pin};
      hws_sync  <= {hws_sync[0], hw_standby_n_pin};
    end
  end

  wire wake_req  = wake_sync[1];
  wire hw_active = !hws_sync[1];

  // ****************************************
  // mode decode
  // ****************************************
  pcc_pkg::pcc_mode_t next_mode;

  wire in_run      = (mode_state == pcc_pkg::PCC_RUN);
  wire in_sleep    = (mode_state == pcc_pkg::PCC_SLEEP);
  wire in_all_stop = (mode_state == pcc_pkg::PCC_ALL_STOP);
  wire in_sw_stby  = (mode_state == pcc_pkg::PCC_SW_STANDBY);
  wire in_wake     = (mode_state == pcc_pkg::PCC_WAKE_WAIT);
  wire in_hw_stby  = (mode_state == pcc_pkg::PCC_HW_STANDBY);
  wire enter_sw    = in_run && sleep_req && standby_select_bit && !hw_active;
  wire leave_hw    = in_hw_stby && !hw_active;

  // ****************************************
  // pending settings and active wait select
  // ****************************************
  logic [1:0] pend_factor;
  logic [2:0] pend_div;
  wire  [1:0] wr_factor  = {pll_factor_hi, pll_factor_lo};
  wire        factor_ok  = pll_factor_wr && (wr_factor != pcc_pkg::FACTOR_BAD);
  wire        div_ok     = clock_divide_wr && (clock_divide_sel <= pcc_pkg::DIV_1_32);
  wire        wait_ok    = standby_wait_wr && (standby_wait_sel != pcc_pkg::WAIT_SEL_BAD);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_factor     <= pcc_pkg::FACTOR_RESET;
      pend_div        <= pcc_pkg::DIV_RESET;
      active_wait_sel <= pcc_pkg::WAIT_SEL_RESET;
    end else if (leave_hw) begin
      pend_factor     <= pcc_pkg::FACTOR_RESET;
      pend_div        <= pcc_pkg::DIV_RESET;
      active_wait_sel <= pcc_pkg::WAIT_SEL_RESET;
    end else begin
      if (factor_ok) begin
        pend_factor <= wr_factor;
      end
      if (div_ok) begin
        pend_div <= clock_divide_sel;
      end
      if (wait_ok) begin
        active_wait_sel <= standby_wait_sel;
      end
    end
  end

  // ****************************************
  // oscillator phase, pll and divider
  // ****************************************
  logic [1:0] osc_phase;
  logic [4:0] div_count;

  wire cpg_run   = !(in_sw_stby || in_hw_stby);
  wire pll_tick  = cpg_run && ((osc_phase & pll_mask(active_factor)) == pll_mask(active_factor));
  wire div_last  = (div_count == div_top(active_div));
  wire sys_tick  = pll_tick && div_last;
  // ratio changes on an oscillator edge, on software standby entry (factor only) or on hardware standby exit
  wire boundary  = sys_tick && (osc_phase == pcc_pkg::OSC_PHASE_LAST);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_phase <= pcc_pkg::OSC_PHASE_FIRST;
    end else if (enter_sw) begin
      osc_phase <= pcc_pkg::OSC_PHASE_FIRST;
    end else if (cpg_run) begin
      osc_phase <= osc_phase + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= pcc_pkg::DIV_COUNT_RESET;
    end else if (enter_sw || leave_hw || boundary || (pll_tick && div_last)) begin
      div_count <= pcc_pkg::DIV_COUNT_RESET;
    end else if (pll_tick) begin
      div_count <= div_count + 5'h01;
    end
  end

  // ****************************************
  // active factor and divide ratio
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_factor <= pcc_pkg::FACTOR_RESET;
      active_div    <= pcc_pkg::DIV_RESET;
    end else if (leave_hw) begin
      active_factor <= pcc_pkg::FACTOR_RESET;
      active_div    <= pcc_pkg::DIV_RESET;
    end else if (enter_sw) begin
      active_factor <= pend_factor;
    end else if (boundary) begin
      active_div <= pend_div;
      if (factor_switch_mode_bit) begin
        active_factor <= pend_factor;
      end
    end
  end

  // ****************************************
  // standby wake wait
  // ****************************************
  logic [WAIT_CNT_W-1:0] wait_count;
  wire                   wait_done = in_wake && sys_tick && (wait_count <= WAIT_CNT_W'(1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_count <= '0;
    end else if (in_sw_stby && wake_req) begin
      wait_count <= wait_cycles(active_wait_sel);
    end else if (in_wake && sys_tick) begin
      wait_count <= wait_count - WAIT_CNT_W'(1);
    end
  end

  // ****************************************
  // mode state machine
  // ****************************************
  always_comb begin
    next_mode = mode_state;
    case (mode_state)
      pcc_pkg::PCC_RUN: begin
        if (sleep_req) begin
          if (standby_select_bit) begin
            next_mode = pcc_pkg::PCC_SW_STANDBY;
          end else if (all_stop_select) begin
            next_mode = pcc_pkg::PCC_ALL_STOP;
          end else begin
            next_mode = pcc_pkg::PCC_SLEEP;
          end
        end
      end
      pcc_pkg::PCC_SLEEP, pcc_pkg::PCC_ALL_STOP: begin
        if (wake_req) begin
          next_mode = pcc_pkg::PCC_RUN;
        end
      end
      pcc_pkg::PCC_SW_STANDBY: begin
        if (wake_req) begin
          next_mode = pcc_pkg::PCC_WAKE_WAIT;
        end
      end
      pcc_pkg::PCC_WAKE_WAIT: begin
        if (wait_done) begin
          next_mode = pcc_pkg::PCC_RUN;
        end
      end
      pcc_pkg::PCC_HW_STANDBY: begin
        if (!hw_active) begin
          next_mode = pcc_pkg::PCC_RUN;
        end
      end
      default: begin
        next_mode = pcc_pkg::PCC_RUN;
      end
    endcase
    if (hw_active) begin
      next_mode = pcc_pkg::PCC_HW_STANDBY;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_state <= pcc_pkg::PCC_RUN;
    end else begin
      mode_state <= next_mode;
    end
  end

  // ****************************************
  // clock enables and module gating
  // ****************************************
  wire timer_stop_bit = module_stop_reg[TIMER_IDX];
  wire periph_mode    = in_run || in_sleep || in_wake;

  assign cpu_clk_en      = sys_tick && in_run;
  assign watchdog_clk_en = sys_tick && (periph_mode || in_all_stop);
  assign pll_clk_en      = pll_tick;
  assign sys_clk_en      = sys_tick;
  assign cpg_running     = cpg_run;
  // pins held in all-stop and software standby
  assign io_hold         = in_all_stop || in_sw_stby;
  assign io_hiz          = in_hw_stby;

  genvar gi;
  generate
    for (gi = 0; gi < N_PERIPH; gi = gi + 1) begin : g_periph
      wire stop_bit  = module_stop_reg[gi];
      wire is_timer  = (gi == TIMER_IDX);
      wire is_serial = (gi == SERIAL_IDX);
      wire is_conv   = (gi == CONV_IDX);
      wire run_ok    = (periph_mode && !stop_bit) || (in_all_stop && is_timer && !timer_stop_bit);
      assign periph_clk_en[gi] = sys_tick && run_ok;
      // reset halt for serial and converter, and for every module in hardware standby
      assign periph_reset[gi]  = in_hw_stby ||
                                 (is_serial && (stop_bit || in_all_stop || in_sw_stby)) ||
                                 (is_conv && in_sw_stby);
    end
  endgenerate

endmodule // pcc_clock_power_ctrl

`default_nettype wire

// ===== test/pcc_periph_model.sv
// pcc_periph_model: cpu and peripherals counting their clock enables.
// assumes: enables and resets come from pcc_clock_power_ctrl.
`timescale 1ns/1ps
`default_nettype none
module pcc_periph_model #(
  parameter int N = 8
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         cpu_clk_en,
  input  wire logic [N-1:0] periph_clk_en,
  input  wire logic [N-1:0] periph_reset,
  output var  logic [15:0]  cpu_cnt,
  output var  logic [15:0]  cnt [N]
);
  always @(posedge core_clk) begin
    if (!resetn) begin
      cpu_cnt <= 16'h0000;
    end else if (cpu_clk_en) begin
      cpu_cnt <= cpu_cnt + 16'h0001;
    end
    for (int i = 0; i < N; i++) begin
      if (!resetn || periph_reset[i]) begin
        cnt[i] <= 16'h0000;
      end else if (periph_clk_en[i]) begin
        cnt[i] <= cnt[i] + 16'h0001;
      end
    end
  end
endmodule // pcc_periph_model
`default_nettype wire

// ===== test/pcc_clock_power_ctrl_asserts.sv
// pcc_clock_power_ctrl_asserts: port checker of the controller.
// assumes: bound to pcc_clock_power_ctrl, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pcc_clock_power_ctrl_asserts #(
  parameter int N_PERIPH   = 8,
  parameter int SERIAL_IDX = 1,
  parameter int CONV_IDX   = 2
) (
  input wire logic                core_clk,
  input wire logic                resetn,
  input wire logic                pll_factor_hi,
  input wire logic                pll_factor_lo,
  input wire logic                pll_factor_wr,
  input wire logic                factor_switch_mode_bit,
  input wire logic                standby_select_bit,
  input wire logic                all_stop_select,
  input wire logic                sleep_req,
  input wire logic [N_PERIPH-1:0] module_stop_reg,
  input wire logic                wake_irq_pin,
  input wire logic                hw_standby_n_pin,
  input wire logic                pll_clk_en,
  input wire logic                sys_clk_en,
  input wire logic                cpu_clk_en,
  input wire logic                watchdog_clk_en,
  input wire logic [N_PERIPH-1:0] periph_clk_en,
  input wire logic [N_PERIPH-1:0] periph_reset,
  input wire logic                cpg_running,
  input wire logic                io_hold,
  input wire logic                io_hiz,
  input wire logic [1:0]          active_factor,
  input wire logic [2:0]          active_div,
  input wire pcc_pkg::pcc_mode_t  mode_state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ****
  // checks
  // ****
  chk_cpu_gate: assert property (cpu_clk_en |-> sys_clk_en && mode_state == pcc_pkg::PCC_RUN)
    else $error("cpu clock outside run");
  chk_cpg_halt: assert property (cpg_running
    == !(mode_state inside {pcc_pkg::PCC_SW_STANDBY, pcc_pkg::PCC_HW_STANDBY}))
    else $error("clock generator state wrong");
  chk_sleep_entry: assert property (mode_state == pcc_pkg::PCC_RUN && sleep_req
    && !standby_select_bit && !all_stop_select && hw_standby_n_pin
    |=> mode_state == pcc_pkg::PCC_SLEEP) else $error("sleep not entered");
  chk_stby_entry: assert property (mode_state == pcc_pkg::PCC_RUN && sleep_req
    && standby_select_bit && hw_standby_n_pin |=> mode_state == pcc_pkg::PCC_SW_STANDBY
    && !cpg_running && periph_reset[CONV_IDX]) else $error("standby not entered");
  chk_x1_spacing: assert property (pll_clk_en && active_factor == pcc_pkg::FACTOR_X1
    |=> (!pll_clk_en || active_factor != pcc_pkg::FACTOR_X1)[*3]) else $error("x1 pulse short");
  chk_x4_rate: assert property (active_factor == pcc_pkg::FACTOR_X4 && cpg_running
    |-> pll_clk_en) else $error("x4 pulse missing");
  chk_div_one: assert property (active_div == pcc_pkg::DIV_1_1
    |-> sys_clk_en == pll_clk_en && (!sys_clk_en || pll_clk_en)) else $error("div 1 wrong");
  chk_periph_gate: assert property (mode_state == pcc_pkg::PCC_RUN
    |-> periph_clk_en == ({N_PERIPH{sys_clk_en}} & ~module_stop_reg)) else $error("gating");
  chk_allstop_state: assert property (mode_state == pcc_pkg::PCC_ALL_STOP
    |-> !cpu_clk_en && io_hold && watchdog_clk_en == sys_clk_en && periph_reset[SERIAL_IDX])
    else $error("all-stop state wrong");
  chk_fast_factor: assert property (factor_switch_mode_bit && pll_factor_wr
    && {pll_factor_hi, pll_factor_lo} == pcc_pkg::FACTOR_X2 && mode_state == pcc_pkg::PCC_RUN
    |-> ##[1:130] active_factor == pcc_pkg::FACTOR_X2) else $error("factor not applied");
  chk_wake_exit: assert property (mode_state == pcc_pkg::PCC_SLEEP && wake_irq_pin
    |-> ##[1:4] mode_state == pcc_pkg::PCC_RUN) else $error("sleep exit late");
  chk_hw_stby: assert property (!hw_standby_n_pin [*4] |=>
    mode_state == pcc_pkg::PCC_HW_STANDBY && io_hiz && &periph_reset) else $error("hw standby");
endmodule // pcc_clock_power_ctrl_asserts
bind pcc_clock_power_ctrl pcc_clock_power_ctrl_asserts #(.N_PERIPH(N_PERIPH),
  .SERIAL_IDX(SERIAL_IDX), .CONV_IDX(CONV_IDX)) i_chk (.core_clk(core_clk), .resetn(resetn),
  .pll_factor_hi(pll_factor_hi), .pll_factor_lo(pll_factor_lo), .pll_factor_wr(pll_factor_wr),
  .factor_switch_mode_bit(factor_switch_mode_bit), .standby_select_bit(standby_select_bit),
  .all_stop_select(all_stop_select), .sleep_req(sleep_req), .module_stop_reg(module_stop_reg),
  .wake_irq_pin(wake_irq_pin), .hw_standby_n_pin(hw_standby_n_pin), .pll_clk_en(pll_clk_en),
  .sys_clk_en(sys_clk_en), .cpu_clk_en(cpu_clk_en), .watchdog_clk_en(watchdog_clk_en),
  .periph_clk_en(periph_clk_en), .periph_reset(periph_reset), .cpg_running(cpg_running),
  .io_hold(io_hold), .io_hiz(io_hiz), .active_factor(active_factor),
  .active_div(active_div), .mode_state(mode_state));
`default_nettype wire

// ===== test/pcc_clock_power_ctrl_tb.sv
// pcc_clock_power_ctrl_tb: directed tests of the clock and power-mode controller.
// assumes: design, package, checker and peripheral model compiled first.
`timescale 1ns/1ps
`default_nettype none
module pcc_clock_power_ctrl_tb;
  logic               core_clk, resetn, fhi, flo, fwr, fmode, dwr, wwr, ssel, asel, sreq;
  logic               wake, hwn, pll, sys, cpu, wdt, cpg, hold, hiz;
  logic [2:0]         dsel, adiv;
  logic [3:0]         wsel, awt;
  logic [7:0]         mstop, pclk, prst;
  logic [1:0]         afac;
  pcc_pkg::pcc_mode_t mode;
  logic [15:0]        cpu_cnt, c0, t0, r3, np, ns;
  logic [15:0]        pcnt [8];
  int                 errors, cmp_count, cyc;

  pcc_clock_power_ctrl #(.WAIT_BASE_CYCLES(1)) i_dut (.core_clk(core_clk), .resetn(resetn),
    .pll_factor_hi(fhi), .pll_factor_lo(flo), .pll_factor_wr(fwr),
    .factor_switch_mode_bit(fmode), .clock_divide_sel(dsel), .clock_divide_wr(dwr),
    .standby_wait_sel(wsel), .standby_wait_wr(wwr), .standby_select_bit(ssel),
    .all_stop_select(asel), .sleep_req(sreq), .module_stop_reg(mstop), .wake_irq_pin(wake),
    .hw_standby_n_pin(hwn), .pll_clk_en(pll), .sys_clk_en(sys), .cpu_clk_en(cpu),
    .watchdog_clk_en(wdt), .periph_clk_en(pclk), .periph_reset(prst), .cpg_running(cpg),
    .io_hold(hold), .io_hiz(hiz), .active_factor(afac), .active_div(adiv),
    .active_wait_sel(awt), .mode_state(mode));
  pcc_periph_model #(.N(8)) i_model (.core_clk(core_clk), .resetn(resetn), .cpu_clk_en(cpu),
    .periph_clk_en(pclk), .periph_reset(prst), .cpu_cnt(cpu_cnt), .cnt(pcnt));

  // ****
  // tasks
  // ****
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr_fac(input logic [1:0] v);
    {fhi, flo} = v;
    fwr = 1'b1;
    tick(1);
    fwr = 1'b0;
    tick(130);
  endtask
  task automatic wr_div(input logic [2:0] v);
    dsel = v;
    dwr = 1'b1;
    tick(1);
    dwr = 1'b0;
    tick(130);
  endtask
  task automatic sleep(input logic s, input logic a);
    ssel = s;
    asel = a;
    sreq = 1'b1;
    tick(1);
    sreq = 1'b0;
  endtask
  // count enables over n cycles
  task automatic cnt_en(input int n);
    np = 16'h0000;
    ns = 16'h0000;
    repeat (n) begin
      np += 16'(pll);
      ns += 16'(sys);
      tick(1);
    end
  endtask
  // wait for a mode, counting system ticks on the way
  task automatic wait_mode(input pcc_pkg::pcc_mode_t m);
    ns = 16'h0000;
    for (int k = 0; k < 400 && mode !== m; k++) begin
      ns += 16'(sys);
      tick(1);
    end
    check(16'(mode), 16'(m));
  endtask
  task automatic wake_up;
    wake = 1'b1;
    wait_mode(pcc_pkg::PCC_RUN);
    wake = 1'b0;
    // let the synchronised wake drain before the next sleep request
    tick(3);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 12000) begin
      errors++;
      results();
    end
  end

  // ****
  // main sequence
  // ****
  initial begin
    {resetn, fhi, flo, fwr, fmode, dwr, wwr, ssel, asel, sreq, wake} = '0;
    {dsel, wsel, mstop} = '0;
    hwn = 1'b1;
    tick(20);
    resetn = 1'b1;
    tick(3);
    check(afac, pcc_pkg::FACTOR_X1);
    check(16'(mode), 16'(pcc_pkg::PCC_RUN));
    check({adiv, awt, cpg}, {pcc_pkg::DIV_1_1, 4'hf, 1'b1});
    cnt_en(64);
    check(np, 16'h0010);
    $display("test reset done");
    fmode = 1'b1;
    wr_fac(pcc_pkg::FACTOR_X2);
    cnt_en(64);
    check(np, 16'h0020);
    wr_fac(pcc_pkg::FACTOR_BAD);
    check(afac, pcc_pkg::FACTOR_X2);
    wr_fac(pcc_pkg::FACTOR_X4);
    cnt_en(64);
    check(np, 16'h0040);
    $display("test factor done");
    for (int d = 0; d < 6; d++) begin
      wr_div(3'(d));
      check(adiv, 16'(d));
      c0 = cpu_cnt;
      cnt_en(256);
      check(ns, 16'(256 >> d));
      check(cpu_cnt - c0, ns);
    end
    wr_div(3'h6);
    check(adiv, pcc_pkg::DIV_1_32);
    wr_div(pcc_pkg::DIV_1_1);
    $display("test divider done");
    fmode = 1'b0;
    wsel = 4'h3;
    wwr = 1'b1;
    tick(1);
    wwr = 1'b0;
    wr_fac(pcc_pkg::FACTOR_X2);
    check(afac, pcc_pkg::FACTOR_X4);
    sleep(1'b1, 1'b0);
    check({afac, cpg, prst[2]}, {pcc_pkg::FACTOR_X2, 2'b01});
    c0 = cpu_cnt;
    t0 = pcnt[0];
    tick(20);
    check({cpu_cnt, pcnt[0]}, {c0, t0});
    wake = 1'b1;
    wait_mode(pcc_pkg::PCC_WAKE_WAIT);
    wake_up();
    check(ns, 16'h0008);
    cnt_en(64);
    check({awt, np}, {4'h3, 16'h0020});
    $display("test standby done");
    mstop = 8'h02;
    sleep(1'b0, 1'b0);
    check(16'(mode), 16'(pcc_pkg::PCC_SLEEP));
    c0 = cpu_cnt;
    t0 = pcnt[0];
    tick(64);
    check(cpu_cnt, c0);
    check(pcnt[0] - t0, 16'h0020);
    check({pcnt[1], prst[1]}, {16'h0000, 1'b1});
    wake_up();
    mstop = 8'h00;
    sleep(1'b0, 1'b1);
    check({16'(mode), hold}, {16'(pcc_pkg::PCC_ALL_STOP), 1'b1});
    t0 = pcnt[0];
    r3 = pcnt[3];
    tick(64);
    check(pcnt[3], r3);
    check(pcnt[0] - t0, 16'h0020);
    wake_up();
    mstop = 8'h01;
    sleep(1'b0, 1'b1);
    t0 = pcnt[0];
    tick(64);
    check(pcnt[0], t0);
    wake_up();
    mstop = 8'h00;
    $display("test sleep done");
    hwn = 1'b0;
    wait_mode(pcc_pkg::PCC_HW_STANDBY);
    check({hiz, cpg, prst}, {2'b10, 8'hff});
    sleep(1'b0, 1'b0);
    check(16'(mode), 16'(pcc_pkg::PCC_HW_STANDBY));
    hwn = 1'b1;
    wait_mode(pcc_pkg::PCC_RUN);
    check({afac, adiv}, {pcc_pkg::FACTOR_X1, pcc_pkg::DIV_1_1});
    $display("test hw standby done");
    results();
  end
endmodule // pcc_clock_power_ctrl_tb
`default_nettype wire
